// file: addr_mode_decode.sv
`timescale 1ns/1ns
module addr_mode_decode
  import addr_mode_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  mode_i,
  input  wire logic        rmw_i,
  input  wire logic [7:0]  index_i,
  output logic             fetch_req_o,
  output logic [15:0]      fetch_addr_o,
  input  wire logic        fetch_ack_i,
  input  wire logic [7:0]  fetch_data_i,
  input  wire logic [15:0] pc_i,
  output logic [1:0]       operand_bytes_o,
  output logic [15:0]      ea_o,
  output logic [7:0]       imm_o,
  output logic             is_imm_o,
  output logic             done_o,
  output logic             illegal_o,
  output logic             busy_o
);
  state_t      state, next_state;
  mode_t       mode, next_mode;
  logic [15:0] opw, next_opw;
  logic [15:0] ptr, next_ptr;
  logic [15:0] ea, next_ea;
  logic [7:0]  imm, next_imm;
  logic        is_imm, next_is_imm;
  logic        ill, next_ill;
  logic [1:0]  nbytes, next_nbytes;

  function automatic logic [1:0] op_len(input mode_t m);
    case (m)
      M_INHERENT, M_IDX_NONE:                 op_len = 2'h0; // RULE_05 RULE_10
      M_DIR_LONG, M_IDX_LONG:                 op_len = 2'h2; // RULE_08 RULE_12
      default:                                op_len = 2'h1; // RULE_06 RULE_07 RULE_11
    endcase
  endfunction

  function automatic logic is_long(input mode_t m);
    is_long = (m == M_DIR_LONG) || (m == M_IDX_LONG) || (m == M_IND_LONG) ||
              (m == M_INDIDX_LONG); // RULE_02
  endfunction

  function automatic logic is_indirect(input mode_t m);
    is_indirect = (m == M_IND_SHORT) || (m == M_IND_LONG) || (m == M_INDIDX_SHORT) ||
                  (m == M_INDIDX_LONG) || (m == M_REL_IND) || (m == M_BIT_IND) ||
                  (m == M_BIT_IND_REL); // RULE_13
  endfunction

  function automatic logic is_indexed(input mode_t m);
    is_indexed = (m == M_IDX_NONE) || (m == M_IDX_SHORT) || (m == M_IDX_LONG) ||
                 (m == M_INDIDX_SHORT) || (m == M_INDIDX_LONG);
  endfunction

  always_comb begin
    next_state  = state;
    next_mode   = mode;
    next_opw    = opw;
    next_ptr    = ptr;
    next_ea     = ea;
    next_imm    = imm;
    next_is_imm = is_imm;
    next_ill    = ill;
    next_nbytes = nbytes;
    case (state)
      S_IDLE, S_DONE, S_ERROR: begin
        if (start_i) begin
          next_mode   = mode_t'(mode_i);
          next_opw    = 16'h0000;
          next_ptr    = 16'h0000;
          next_is_imm = 1'b0;
          next_ill    = 1'b0;
          next_nbytes = op_len(mode_t'(mode_i));
          if (mode_i >= MODE_COUNT || (rmw_i && is_long(mode_t'(mode_i)))) begin // RULE_01 RULE_04
            next_ill   = 1'b1;
            next_state = S_ERROR;
          end else if (mode_i == M_INHERENT) begin
            next_ea    = 16'h0000; // RULE_05
            next_state = S_DONE;
          end else if (mode_i == M_IDX_NONE) begin
            next_ea    = {8'h00, index_i}; // RULE_10
            next_state = S_DONE;
          end else begin
            next_state = S_OP1;
          end
        end else begin
          next_state = S_IDLE;
        end
      end
      S_OP1: begin
        if (fetch_ack_i) begin
          next_opw = {8'h00, fetch_data_i};
          if (mode == M_IMMEDIATE) begin
            next_imm    = fetch_data_i; // RULE_06
            next_is_imm = 1'b1;
            next_ea     = 16'h0000;
            next_state  = S_DONE;
          end else if (op_len(mode) == 2'h2) begin
            next_state = S_OP2;
          end else if (is_indirect(mode)) begin
            next_state = S_PTR1; // RULE_13
          end else if (mode == M_IDX_SHORT) begin
            next_ea    = {8'h00, fetch_data_i} + {8'h00, index_i}; // RULE_11 RULE_16 RULE_09
            next_state = S_DONE;
          end else begin
            next_ea    = {8'h00, fetch_data_i}; // RULE_07 RULE_03
            next_state = S_DONE;
          end
        end
      end
      S_OP2: begin
        if (fetch_ack_i) begin
          next_opw   = {opw[7:0], fetch_data_i}; // high byte first
          next_ea    = (mode == M_IDX_LONG) ? {opw[7:0], fetch_data_i} + {8'h00, index_i}
                                            : {opw[7:0], fetch_data_i}; // RULE_08 RULE_12
          next_state = S_DONE;
        end
      end
      S_PTR1: begin
        if (fetch_ack_i) begin
          next_ptr = {8'h00, fetch_data_i};
          if (is_long(mode)) begin
            next_state = S_PTR2; // RULE_15
          end else begin
            // short pointer: one byte, indexed form may cross page zero
            next_ea    = (mode == M_INDIDX_SHORT) ?
                         {8'h00, fetch_data_i} + {8'h00, index_i} :
                         {8'h00, fetch_data_i}; // RULE_14
            next_state = S_DONE;
          end
        end
      end
      S_PTR2: begin
        if (fetch_ack_i) begin
          next_ptr   = {ptr[7:0], fetch_data_i};
          next_ea    = is_indexed(mode) ? {ptr[7:0], fetch_data_i} + {8'h00, index_i}
                                        : {ptr[7:0], fetch_data_i}; // RULE_15
          next_state = S_DONE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state  <= S_IDLE;
      mode   <= M_INHERENT;
      opw    <= 16'h0000;
      ptr    <= 16'h0000;
      ea     <= 16'h0000;
      imm    <= 8'h00;
      is_imm <= 1'b0;
      ill    <= 1'b0;
      nbytes <= 2'h0;
    end else begin
      state  <= next_state;
      mode   <= next_mode;
      opw    <= next_opw;
      ptr    <= next_ptr;
      ea     <= next_ea;
      imm    <= next_imm;
      is_imm <= next_is_imm;
      ill    <= next_ill;
      nbytes <= next_nbytes;
    end
  end

  // operand bytes come from pc onward; the pointer is read in page zero
  always_comb begin
    fetch_req_o  = 1'b0;
    fetch_addr_o = 16'h0000;
    case (state)
      S_OP1: begin
        fetch_req_o  = 1'b1;
        fetch_addr_o = pc_i;
      end
      S_OP2: begin
        fetch_req_o  = 1'b1;
        fetch_addr_o = pc_i + 16'h0001;
      end
      S_PTR1: begin
        fetch_req_o  = 1'b1;
        fetch_addr_o = {8'h00, opw[7:0]}; // RULE_13
      end
      S_PTR2: begin
        fetch_req_o  = 1'b1;
        fetch_addr_o = {8'h00, opw[7:0] + 8'h01}; // wraps inside page zero
      end
      default: begin
        fetch_req_o  = 1'b0;
        fetch_addr_o = 16'h0000;
      end
    endcase
  end

  assign ea_o            = ea;
  assign imm_o           = imm;
  assign is_imm_o        = is_imm;
  assign operand_bytes_o = nbytes;
  assign done_o          = (state == S_DONE);
  assign illegal_o       = ill;
  assign busy_o          = (state == S_OP1) || (state == S_OP2) || (state == S_PTR1) ||
                           (state == S_PTR2);

  sequence short_idx_seq;
    state == S_OP1 && mode == M_IDX_SHORT && fetch_ack_i;
  endsequence

  short_idx_sum_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_16
    short_idx_seq |=> done_o && ea_o == {8'h00, $past(fetch_data_i)} + {8'h00, $past(index_i)})
    else $error("short indexed sum wrong");

  inherent_done_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_05
    (!busy_o && start_i && mode_i == M_INHERENT) |=> done_o && !fetch_req_o && ea_o == 16'h0000)
    else $error("inherent not one byte");

  rmw_long_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_04
    (!busy_o && start_i && rmw_i && (mode_i == M_DIR_LONG || mode_i == M_IDX_LONG))
    |=> illegal_o && !done_o)
    else $error("long rmw accepted");

  imm_value_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_06
    (state == S_OP1 && mode == M_IMMEDIATE && fetch_ack_i)
    |=> is_imm_o && imm_o == $past(fetch_data_i) && done_o)
    else $error("immediate operand wrong");

  short_page_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_03
    (done_o && (mode == M_DIR_SHORT || mode == M_IND_SHORT || mode == M_IDX_NONE))
    |-> ea_o <= PAGE_ZERO_TOP)
    else $error("short form left page zero");

  idx_range_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_11
    (done_o && (mode == M_IDX_SHORT || mode == M_INDIDX_SHORT)) |-> ea_o <= SHORT_IDX_TOP)
    else $error("short indexed out of range");

  ptr_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_13
    (state == S_OP1 && fetch_ack_i && is_indirect(mode))
    |=> fetch_req_o && fetch_addr_o == {8'h00, $past(fetch_data_i)})
    else $error("pointer not read at page zero");

  long_dir_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_08
    (state == S_OP2 && mode == M_DIR_LONG && fetch_ack_i)
    |=> done_o && ea_o == {$past(opw[7:0]), $past(fetch_data_i)})
    else $error("long direct address wrong");

  long_len_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_12
    (!busy_o && start_i && mode_i == M_IDX_LONG && !rmw_i) |=> operand_bytes_o == 2'h2)
    else $error("long indexed length wrong");

  long_ind_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_15
    (state == S_PTR1 && fetch_ack_i && mode == M_IND_LONG) |=> state == S_PTR2)
    else $error("long pointer not two bytes");
endmodule

// file: addr_mode_pkg.sv
// Overview of operation
// RULE_01 - seventeen modes in seven groups decoded
// RULE_02 - long forms reach 64 Kbyte, more bytes
// RULE_03 - short forms stay in page zero; short indexed and short indirect indexed ea here reach up to 1FE
// RULE_04 - read-modify-write only with short forms
// RULE_05 - inherent: one byte, no operand fetch
// RULE_06 - immediate: next byte is operand value
// RULE_07 - short direct: one address byte
// RULE_08 - long direct: two address bytes
// RULE_09 - indexed address is unsigned index plus offset
// RULE_10 - no-offset indexed: index alone addresses
// RULE_11 - short indexed: one offset byte, to 1FE
// RULE_12 - long indexed: two offset bytes, 64K
// RULE_13 - indirect: pointer read from page zero
// RULE_14 - short indirect: byte pointer, page zero
// RULE_15 - long indirect: word pointer, full space
// RULE_16 - short indexed sum kept nine bits wide
package addr_mode_pkg;
  typedef enum logic [4:0] {
    M_INHERENT      = 5'h00,
    M_IMMEDIATE     = 5'h01,
    M_DIR_SHORT     = 5'h02,
    M_DIR_LONG      = 5'h03,
    M_IDX_NONE      = 5'h04,
    M_IDX_SHORT     = 5'h05,
    M_IDX_LONG      = 5'h06,
    M_IND_SHORT     = 5'h07,
    M_IND_LONG      = 5'h08,
    M_INDIDX_SHORT  = 5'h09,
    M_INDIDX_LONG   = 5'h0A,
    M_REL_DIR       = 5'h0B,
    M_REL_IND       = 5'h0C,
    M_BIT_DIR       = 5'h0D,
    M_BIT_IND       = 5'h0E,
    M_BIT_DIR_REL   = 5'h0F,
    M_BIT_IND_REL   = 5'h10
  } mode_t;
  localparam logic [4:0] MODE_COUNT = 5'h11;
  localparam logic [2:0] GROUP_COUNT = 3'h7;
  typedef enum logic [2:0] {
    G_INHERENT = 3'h0, G_IMMEDIATE = 3'h1, G_DIRECT = 3'h2, G_INDEXED = 3'h3,
    G_INDIRECT = 3'h4, G_RELATIVE = 3'h5, G_BIT = 3'h6
  } group_t;
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_OP1   = 7'h02,
    S_OP2   = 7'h04,
    S_PTR1  = 7'h08,
    S_PTR2  = 7'h10,
    S_DONE  = 7'h20,
    S_ERROR = 7'h40
  } state_t;
  localparam logic [15:0] PAGE_ZERO_TOP = 16'h00FF;
  localparam logic [15:0] SHORT_IDX_TOP = 16'h01FE;
endpackage

// file: code_memory_model.sv
`timescale 1ns/1ns
module code_memory_model (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        fetch_req_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic [1:0]  wait_i,
  output logic             fetch_ack_o,
  output logic [7:0]       fetch_data_o
);
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic [7:0] noise;
  logic [7:0] next_noise;
  // scrambled contents so neighbouring bytes and pages differ
  function automatic logic [7:0] content(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  always_comb begin
    next_noise = noise + 8'h3B;
    next_wait_cnt = wait_cnt + 2'h1;
    if (!fetch_req_i || fetch_ack_o) begin
      next_wait_cnt = 2'h0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wait_cnt <= 2'h0;
      noise <= 8'h5C;
    end else begin
      wait_cnt <= next_wait_cnt;
      noise <= next_noise;
    end
  end
  assign fetch_ack_o = fetch_req_i && (wait_cnt == wait_i);
  // data is not held between acks: stale bytes must never look right
  assign fetch_data_o = fetch_ack_o ? content(fetch_addr_i) : noise;
endmodule

// file: test_cpu_addressing_mode_decode.sv
`timescale 1ns/1ns
module test_cpu_addressing_mode_decode;
  import addr_mode_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        reset_i, start_i, rmw_i, fetch_req_o, fetch_ack_i;
  logic        is_imm_o, done_o, illegal_o, busy_o;
  logic [4:0]  mode_i;
  logic [7:0]  index_i, fetch_data_i, imm_o;
  logic [15:0] pc_i, fetch_addr_o, ea_o;
  logic [1:0]  operand_bytes_o, mem_wait;
  int          miscompares, total_checks;
  always #20 core_clk_i = ~core_clk_i;
  addr_mode_decode addr_mode_decode_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .start_i(start_i), .mode_i(mode_i), .rmw_i(rmw_i), .index_i(index_i),
    .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o), .fetch_ack_i(fetch_ack_i),
    .fetch_data_i(fetch_data_i), .pc_i(pc_i), .operand_bytes_o(operand_bytes_o),
    .ea_o(ea_o), .imm_o(imm_o), .is_imm_o(is_imm_o), .done_o(done_o),
    .illegal_o(illegal_o), .busy_o(busy_o));
  code_memory_model code_memory_model_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o), .wait_i(mem_wait),
    .fetch_ack_o(fetch_ack_i), .fetch_data_o(fetch_data_i));
  function automatic logic [15:0] mb(input logic [15:0] a);
    return {8'h00, a[7:0] ^ a[15:8] ^ 8'hA5};
  endfunction
  // two-byte word, high byte from the lower address
  function automatic logic [15:0] mw(input logic [15:0] hi, input logic [15:0] lo);
    return (mb(hi) << 8) | mb(lo);
  endfunction
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_flag(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // full=0 where only acceptance matters (encoding of ea left to the design)
  task automatic run_op(input logic [4:0] m, input logic r, input logic [7:0] x,
      input logic [15:0] pc, input logic [1:0] w, input logic poke, input logic full,
      input logic ill, input logic [1:0] nb, input logic [15:0] ea, input int lat_exp);
    int lat;
    @(posedge core_clk_i);
    #1;
    mem_wait = w; start_i = 1'b1; mode_i = m; rmw_i = r; index_i = x; pc_i = pc;
    @(posedge core_clk_i);
    #1;
    start_i = 1'b0;
    lat = 1;
    while (!(done_o === 1'b1 || illegal_o === 1'b1) && lat < 40) begin
      @(posedge core_clk_i);
      #1;
      lat++;
      if (poke) begin
        start_i = (lat == 2);
        mode_i = (lat == 2) ? 5'h11 : m;
      end
    end
    check_flag("illegal_o", ill, illegal_o);
    check_flag("done_o", !ill, done_o);
    if (full) begin
      check_word("operand_bytes_o", {14'h0, nb}, {14'h0, operand_bytes_o});
      check_word("ea_o", ea, ea_o);
      check_word("latency", 16'(lat_exp), 16'(lat));
      check_flag("is_imm_o", m == 5'h01, is_imm_o);
    end
  endtask
  task automatic t_reset_state;
    check_flag("busy_o", 1'b0, busy_o);
    check_flag("done_o", 1'b0, done_o);
    check_word("ea_o", 16'h0000, ea_o);
  endtask
  task automatic t_inherent;
    run_op(5'h00, 0, 8'h33, 16'h1234, 2'h0, 0, 1, 0, 2'h0, 16'h0000, 1);
  endtask
  task automatic t_immediate;
    run_op(5'h01, 0, 8'h00, 16'h2000, 2'h1, 0, 1, 0, 2'h1, 16'h0000, 3);
    check_word("imm_o", mb(16'h2000), {8'h00, imm_o});
  endtask
  task automatic t_direct;
    run_op(5'h02, 0, 8'h00, 16'h0310, 2'h0, 0, 1, 0, 2'h1, mb(16'h0310), 2);
    run_op(5'h03, 0, 8'h00, 16'h4321, 2'h1, 0, 1, 0, 2'h2,
           mw(16'h4321, 16'h4322), 5);
  endtask
  task automatic t_indexed;
    run_op(5'h04, 0, 8'hC7, 16'h0900, 2'h0, 0, 1, 0, 2'h0, 16'h00C7, 1);
    run_op(5'h05, 0, 8'hFF, 16'h005A, 2'h0, 0, 1, 0, 2'h1, 16'h01FE, 2);
    run_op(5'h06, 0, 8'hF0, 16'h8000, 2'h0, 0, 1, 0, 2'h2,
           mw(16'h8000, 16'h8001) + 16'h00F0, 3);
  endtask
  task automatic t_indirect;
    run_op(5'h07, 0, 8'h00, 16'h005A, 2'h0, 0, 1, 0, 2'h1, mb(16'h00FF), 3);
    run_op(5'h08, 0, 8'h00, 16'h005A, 2'h0, 0, 1, 0, 2'h1,
           mw(16'h00FF, 16'h0000), 4);
    run_op(5'h09, 0, 8'hA6, 16'h005A, 2'h0, 0, 1, 0, 2'h1, 16'h0100, 3);
    run_op(5'h0A, 0, 8'h10, 16'h005A, 2'h0, 0, 1, 0, 2'h1, 16'h5AB5, 4);
  endtask
  task automatic t_groups;
    for (int m = 'h0B; m <= 'h10; m++) begin
      run_op(5'(m), 0, 8'h12, 16'h0700, 2'h0, 0, 0, 0, 2'h0, 16'h0, 0);
    end
    run_op(5'h11, 0, 8'h12, 16'h0700, 2'h0, 0, 0, 1, 2'h0, 16'h0, 0);
  endtask
  task automatic t_rmw;
    logic [4:0] forms [6] = '{5'h02, 5'h05, 5'h07, 5'h03, 5'h06, 5'h08};
    for (int i = 0; i < 6; i++) begin
      run_op(forms[i], 1, 8'h01, 16'h0040, 2'h0, 0, 0, i > 2, 2'h0, 16'h0, 0);
    end
  endtask
  task automatic t_refused;
    run_op(5'h03, 0, 8'h00, 16'hBEEF, 2'h2, 1, 1, 0, 2'h2,
           mw(16'hBEEF, 16'hBEF0), 7);
  endtask
  initial begin
    reset_i = 1'b1; start_i = 1'b0; mode_i = 5'h00; rmw_i = 1'b0;
    index_i = 8'h00; pc_i = 16'h0000; mem_wait = 2'h0;
    miscompares = 0; total_checks = 0;
    repeat (20) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    t_reset_state;
    t_inherent;
    t_immediate;
    t_direct;
    t_indexed;
    t_indirect;
    t_groups;
    t_rmw;
    t_refused;
    give_verdict;
  end
  // about 110 cycles of work expected; the margin covers slow memory answers
  initial begin
    #(40 * 4000);
    miscompares++;
    give_verdict;
  end
endmodule
